// >>> core/tmr_pkg.sv
/*
  Constants shared by the timer pair: register indices, field positions,
  reset values, timing counts and the decoded mode type.
  Assumes a 125 MHz i_mclk, which is also the peripheral clock.
*/
// Summary of operation
// - Timer b matches timer a in modes 0-2; its mode 3 holds the count.
// - Timer b uses upper mode nibble and control bits 2, 3, 6, 7.
// - Without gating, run bit lets the selected input increment the low byte.
// - With gating and run set, the ext pin b level also controls counting.
// - Rollover from all ones to zeros sets overflow flag b.
// - In timer a mode 3, overflow b and run b serve timer a's upper half.
// - Mode 0: 13-bit, low 5 bits prescale by 32 into high byte.
// - Mode 1: 16-bit, high byte cascaded above the low byte.
// - Mode 2: 8-bit low byte, overflow sets flag, reloads from high byte.
// - Mode 3 on timer b halts it and keeps the count.
// - Overflow flag is the timer interrupt, cleared on vectoring.
// - Timer interrupt needs its own enable and the global enable.
// - Control bit 5 is set on timer a overflow, cleared on vectoring.
// - Ext flag a set on detection; vector clears it only in edge mode.
// - Type bit b: zero low-level, one falling-edge detection on pin b.
// - The control register resets to all zeros.
// - With gating set, count only while pin b is high and either run is set or timer a is in mode 3.
// - With source select set, count falling edges on the count pin.
// - Timer operation increments once per six-clock peripheral cycle.
// - Count pin sampled per peripheral cycle; high then low increments.
package tmr_pkg;

  localparam int unsigned PER_CYCLE_CLKS = 6;
  localparam logic [2:0] PER_CYCLE_LAST = 3'(PER_CYCLE_CLKS - 1);

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h88;
  localparam logic [7:0] IDX_MODE = 8'h89;
  localparam logic [7:0] IDX_LOW_A = 8'h8a;
  localparam logic [7:0] IDX_LOW_B = 8'h8b;
  localparam logic [7:0] IDX_HIGH_A = 8'h8c;
  localparam logic [7:0] IDX_HIGH_B = 8'h8d;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'ha8;

  localparam int CTL_OVF_B = 7;
  localparam int CTL_RUN_B = 6;
  localparam int CTL_OVF_A = 5;
  localparam int CTL_RUN_A = 4;
  localparam int CTL_EXT_FLAG_B = 3;
  localparam int CTL_EXT_TYPE_B = 2;
  localparam int CTL_EXT_FLAG_A = 1;
  localparam int CTL_EXT_TYPE_A = 0;

  // Per timer nibble: gate at +3, source at +2, mode at +1..+0
  localparam int MOD_NIBBLE = 4;
  localparam int MOD_GATE_OFS = 3;
  localparam int MOD_SRC_OFS = 2;
  localparam int MOD_MODE_OFS = 0;
  localparam logic [1:0] MODE_BITS_HOLD = 2'h3;

  localparam int IEN_GLOBAL = 7;
  localparam int IEN_TIMER_B = 3;
  localparam int IEN_EXT_B = 2;
  localparam int IEN_TIMER_A = 1;
  localparam int IEN_EXT_A = 0;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [4:0] PRESCALE_LAST = 5'h1f;
  localparam logic [7:0] BYTE_LAST = 8'hff;

  typedef enum logic [3:0] {
    MODE_13BIT = 4'b0001,
    MODE_16BIT = 4'b0010,
    MODE_RELOAD = 4'b0100,
    MODE_HOLD = 4'b1000
  } timer_mode_e;

endpackage

// >>> core/timer_link_if.sv
/*
  Link between the control block and one timer counting unit.
  Assumes the control side drives ticks and writes, the unit the counts.
*/
`timescale 1ns/1ns
`default_nettype none
interface timer_link_if;
  tmr_pkg::timer_mode_e mode;
  logic split_ok;
  logic count_tick;
  logic high_tick;
  logic wr_low;
  logic wr_high;
  logic [7:0] wr_data;
  logic [7:0] low_byte;
  logic [7:0] high_byte;
  logic ovf_main;
  logic ovf_high;
  modport ctrl (output mode, split_ok, count_tick, high_tick, wr_low, wr_high, wr_data,
                input low_byte, high_byte, ovf_main, ovf_high);
  modport unit (input mode, split_ok, count_tick, high_tick, wr_low, wr_high, wr_data,
                output low_byte, high_byte, ovf_main, ovf_high);
endinterface
`default_nettype wire

// >>> core/count_sampler.sv
/*
  Count source for one timer: peripheral-cycle tick or sampled pin edges.
  Assumes the pin is synchronous to i_mclk and i_per_tick is a pulse.
*/
`timescale 1ns/1ns
`default_nettype none
module count_sampler (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_per_tick,
  input wire logic i_pin,
  input wire logic i_use_pin,
  output logic o_tick
);
  logic sample;
  logic pin_fell;

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sample <= 1'b1;
    else if (i_per_tick)
      sample <= i_pin;
  end

  // High sample then low sample, one peripheral cycle apart
  assign pin_fell = i_per_tick & sample & ~i_pin;
  assign o_tick = i_use_pin ? pin_fell : i_per_tick;
endmodule
`default_nettype wire

// >>> core/timer_unit.sv
/*
  One timer counting unit: low and high count bytes and the four modes.
  Assumes ticks are already gated by run and gate control.
*/
`timescale 1ns/1ns
`default_nettype none
module timer_unit (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  timer_link_if.unit link
);
  logic [7:0] low_byte;
  logic [7:0] high_byte;
  logic ovf_main;
  logic ovf_high;
  logic [7:0] next_low;
  logic [7:0] next_high;
  logic next_ovf_main;
  logic next_ovf_high;
  logic tick;
  logic pre_wrap;
  logic low_wrap;
  logic high_full;

  assign tick = link.count_tick;
  assign pre_wrap = tick && (low_byte[4:0] == tmr_pkg::PRESCALE_LAST);
  assign low_wrap = tick && (low_byte == tmr_pkg::BYTE_LAST);
  assign high_full = (high_byte == tmr_pkg::BYTE_LAST);

  always_comb
  begin
    next_low = low_byte;
    next_high = high_byte;
    next_ovf_main = 1'b0;
    next_ovf_high = 1'b0;
    unique case (link.mode)
      tmr_pkg::MODE_13BIT:
      begin
        // Upper three low bits are left alone
        if (pre_wrap)
        begin
          next_low = {low_byte[7:5], 5'h00};
          next_high = high_byte + 8'h01;
          next_ovf_main = high_full;
        end
        else if (tick)
          next_low = {low_byte[7:5], low_byte[4:0] + 5'h01};
      end
      tmr_pkg::MODE_16BIT:
      begin
        if (low_wrap)
        begin
          next_low = 8'h00;
          next_high = high_byte + 8'h01;
          next_ovf_main = high_full;
        end
        else if (tick)
          next_low = low_byte + 8'h01;
      end
      tmr_pkg::MODE_RELOAD:
      begin
        if (low_wrap)
        begin
          next_low = high_byte;
          next_ovf_main = 1'b1;
        end
        else if (tick)
          next_low = low_byte + 8'h01;
      end
      tmr_pkg::MODE_HOLD:
      begin
        // Split-capable unit runs two 8-bit counters, otherwise it holds
        if (link.split_ok)
        begin
          if (low_wrap)
          begin
            next_low = 8'h00;
            next_ovf_main = 1'b1;
          end
          else if (tick)
            next_low = low_byte + 8'h01;
          if (link.high_tick)
          begin
            next_high = high_byte + 8'h01;
            next_ovf_high = high_full;
          end
        end
      end
    endcase
    if (link.wr_low)
      next_low = link.wr_data;
    if (link.wr_high)
      next_high = link.wr_data;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      low_byte <= tmr_pkg::COUNT_RESET;
      high_byte <= tmr_pkg::COUNT_RESET;
      ovf_main <= 1'b0;
      ovf_high <= 1'b0;
    end
    else
    begin
      low_byte <= next_low;
      high_byte <= next_high;
      ovf_main <= next_ovf_main;
      ovf_high <= next_ovf_high;
    end
  end

  assign link.low_byte = low_byte;
  assign link.high_byte = high_byte;
  assign link.ovf_main = ovf_main;
  assign link.ovf_high = ovf_high;
endmodule
`default_nettype wire

// >>> core/timer_pair_top.sv
/*
  Timer pair with shared control and status register, mode register,
  external interrupt flags and interrupt requests, on a Wishbone slave.
  Assumes classic Wishbone, one clock, pins synchronous to i_mclk and
  a processor that pulses a vector input when it enters each routine.
*/
`timescale 1ns/1ns
`default_nettype none
module timer_pair_top (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_count_input_pin_a,
  input wire logic i_count_input_pin_b,
  input wire logic i_ext_irq_pin_a_n,
  input wire logic i_ext_irq_pin_b_n,
  input wire logic i_vector_timer_a,
  input wire logic i_vector_timer_b,
  input wire logic i_vector_ext_a,
  input wire logic i_vector_ext_b,
  output logic o_irq_timer_a,
  output logic o_irq_timer_b,
  output logic o_irq_ext_a,
  output logic o_irq_ext_b
);
  logic [1:0] rst_sync;
  logic rst_n;

  logic [7:0] control_reg;
  logic [7:0] mode_reg;
  logic [7:0] irq_enable_reg;
  logic [7:0] next_control;
  logic [2:0] per_cnt;
  logic per_tick;
  logic ext_prev_a;
  logic ext_prev_b;

  logic [7:0] low_byte [2];
  logic [7:0] high_byte [2];
  logic ovf_main [2];
  logic ovf_high [2];
  logic src_tick [2];
  logic run_eff [2];
  logic gate_ok [2];
  logic count_pin [2];
  logic pin_high [2];
  logic wr_low [2];
  logic wr_high [2];

  logic [7:0] adr_idx;
  logic bus_req;
  logic bus_wr;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic wr_control;
  logic wr_mode;
  logic wr_irq_enable;
  logic split_a;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // Bus decode; data lives in byte lane 0
  assign adr_idx = i_wb_adr[9:2];
  assign bus_req = i_wb_cyc & i_wb_stb;
  // Write commits on the edge where the master sees ack
  assign bus_wr = bus_req & i_wb_we & o_wb_ack & i_wb_sel[0];
  assign wr_byte = i_wb_dat[7:0];
  assign wr_control = bus_wr && (adr_idx == tmr_pkg::IDX_CONTROL);
  assign wr_mode = bus_wr && (adr_idx == tmr_pkg::IDX_MODE);
  assign wr_irq_enable = bus_wr && (adr_idx == tmr_pkg::IDX_IRQ_ENABLE);
  assign wr_low[0] = bus_wr && (adr_idx == tmr_pkg::IDX_LOW_A);
  assign wr_low[1] = bus_wr && (adr_idx == tmr_pkg::IDX_LOW_B);
  assign wr_high[0] = bus_wr && (adr_idx == tmr_pkg::IDX_HIGH_A);
  assign wr_high[1] = bus_wr && (adr_idx == tmr_pkg::IDX_HIGH_B);

  assign rd_byte =
    (adr_idx == tmr_pkg::IDX_CONTROL) ? control_reg :
    (adr_idx == tmr_pkg::IDX_MODE) ? mode_reg :
    (adr_idx == tmr_pkg::IDX_LOW_A) ? low_byte[0] :
    (adr_idx == tmr_pkg::IDX_LOW_B) ? low_byte[1] :
    (adr_idx == tmr_pkg::IDX_HIGH_A) ? high_byte[0] :
    (adr_idx == tmr_pkg::IDX_HIGH_B) ? high_byte[1] :
    (adr_idx == tmr_pkg::IDX_IRQ_ENABLE) ? irq_enable_reg :
    8'h00;

  // One ack per request, dropped the cycle after; unmapped reads give zero
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= bus_req & ~o_wb_ack;
      o_wb_dat <= {24'h00_0000, rd_byte};
    end
  end

  // Peripheral cycle divider shared by both timers
  assign per_tick = (per_cnt == tmr_pkg::PER_CYCLE_LAST);
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      per_cnt <= 3'h0;
    else if (per_tick)
      per_cnt <= 3'h0;
    else
      per_cnt <= per_cnt + 3'h1;
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= tmr_pkg::MODE_RESET;
      irq_enable_reg <= tmr_pkg::IRQ_ENABLE_RESET;
    end
    else
    begin
      if (wr_mode)
        mode_reg <= wr_byte;
      if (wr_irq_enable)
        irq_enable_reg <= wr_byte;
    end
  end

  assign split_a = (mode_reg[1:0] == tmr_pkg::MODE_BITS_HOLD);
  assign count_pin[0] = i_count_input_pin_a;
  assign count_pin[1] = i_count_input_pin_b;
  // Gate pins are active low interrupt pins; gating counts while high
  assign pin_high[0] = i_ext_irq_pin_a_n;
  assign pin_high[1] = i_ext_irq_pin_b_n;
  assign run_eff[0] = control_reg[tmr_pkg::CTL_RUN_A];
  // Run bit b belongs to timer a's upper half while timer a splits
  assign run_eff[1] = split_a ? 1'b1 : control_reg[tmr_pkg::CTL_RUN_B];

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_timer
      localparam int NIB = g * tmr_pkg::MOD_NIBBLE;
      logic [1:0] mode_bits;
      logic gate_bit;
      logic src_bit;
      timer_link_if link ();

      assign mode_bits = mode_reg[NIB + tmr_pkg::MOD_MODE_OFS +: 2];
      assign gate_bit = mode_reg[NIB + tmr_pkg::MOD_GATE_OFS];
      assign src_bit = mode_reg[NIB + tmr_pkg::MOD_SRC_OFS];
      // Gating off: run alone; gating on: pin must also be high
      assign gate_ok[g] = ~gate_bit | pin_high[g];

      count_sampler u_sampler (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_per_tick(per_tick),
        .i_pin(count_pin[g]),
        .i_use_pin(src_bit),
        .o_tick(src_tick[g])
      );

      assign link.mode = (mode_bits == 2'h0) ? tmr_pkg::MODE_13BIT :
                         (mode_bits == 2'h1) ? tmr_pkg::MODE_16BIT :
                         (mode_bits == 2'h2) ? tmr_pkg::MODE_RELOAD :
                         tmr_pkg::MODE_HOLD;
      assign link.split_ok = (g == 0);
      assign link.count_tick = src_tick[g] & run_eff[g] & gate_ok[g];
      // Upper half of timer a is locked to peripheral cycles and run bit b
      assign link.high_tick = (g == 0) ? (per_tick & control_reg[tmr_pkg::CTL_RUN_B]) :
                              1'b0;
      assign link.wr_low = wr_low[g];
      assign link.wr_high = wr_high[g];
      assign link.wr_data = wr_byte;
      assign low_byte[g] = link.low_byte;
      assign high_byte[g] = link.high_byte;
      assign ovf_main[g] = link.ovf_main;
      assign ovf_high[g] = link.ovf_high;

      timer_unit u_unit (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .link(link)
      );
    end
  endgenerate

  // Flag events and clears; a hardware set beats any clear in one cycle
  logic set_ovf_a;
  logic set_ovf_b;
  logic set_ext_a;
  logic set_ext_b;
  logic clr_ovf_a;
  logic clr_ovf_b;
  logic clr_ext_a;
  logic clr_ext_b;
  logic type_a;
  logic type_b;
  logic fell_a;
  logic fell_b;

  assign type_a = control_reg[tmr_pkg::CTL_EXT_TYPE_A];
  assign type_b = control_reg[tmr_pkg::CTL_EXT_TYPE_B];
  assign fell_a = ext_prev_a & ~i_ext_irq_pin_a_n;
  assign fell_b = ext_prev_b & ~i_ext_irq_pin_b_n;

  assign set_ovf_a = ovf_main[0] |
                     (wr_control & wr_byte[tmr_pkg::CTL_OVF_A]);
  assign set_ovf_b = (split_a ? ovf_high[0] : ovf_main[1]) |
                     (wr_control & wr_byte[tmr_pkg::CTL_OVF_B]);
  assign clr_ovf_a = i_vector_timer_a |
                     (wr_control & ~wr_byte[tmr_pkg::CTL_OVF_A]);
  assign clr_ovf_b = i_vector_timer_b |
                     (wr_control & ~wr_byte[tmr_pkg::CTL_OVF_B]);

  // Level mode mirrors the low pin; edge mode latches a falling edge
  assign set_ext_a = (type_a ? fell_a : ~i_ext_irq_pin_a_n) |
                     (wr_control & wr_byte[tmr_pkg::CTL_EXT_FLAG_A]);
  assign set_ext_b = (type_b ? fell_b : ~i_ext_irq_pin_b_n) |
                     (wr_control & wr_byte[tmr_pkg::CTL_EXT_FLAG_B]);
  assign clr_ext_a = (type_a ? i_vector_ext_a : i_ext_irq_pin_a_n) |
                     (wr_control & ~wr_byte[tmr_pkg::CTL_EXT_FLAG_A]);
  assign clr_ext_b = (type_b ? i_vector_ext_b : i_ext_irq_pin_b_n) |
                     (wr_control & ~wr_byte[tmr_pkg::CTL_EXT_FLAG_B]);

  always_comb
  begin
    next_control = control_reg;
    if (wr_control)
    begin
      next_control[tmr_pkg::CTL_RUN_B] = wr_byte[tmr_pkg::CTL_RUN_B];
      next_control[tmr_pkg::CTL_RUN_A] = wr_byte[tmr_pkg::CTL_RUN_A];
      next_control[tmr_pkg::CTL_EXT_TYPE_B] = wr_byte[tmr_pkg::CTL_EXT_TYPE_B];
      next_control[tmr_pkg::CTL_EXT_TYPE_A] = wr_byte[tmr_pkg::CTL_EXT_TYPE_A];
    end
    next_control[tmr_pkg::CTL_OVF_B] = set_ovf_b |
      (control_reg[tmr_pkg::CTL_OVF_B] & ~clr_ovf_b);
    next_control[tmr_pkg::CTL_OVF_A] = set_ovf_a |
      (control_reg[tmr_pkg::CTL_OVF_A] & ~clr_ovf_a);
    next_control[tmr_pkg::CTL_EXT_FLAG_B] = set_ext_b |
      (control_reg[tmr_pkg::CTL_EXT_FLAG_B] & ~clr_ext_b);
    next_control[tmr_pkg::CTL_EXT_FLAG_A] = set_ext_a |
      (control_reg[tmr_pkg::CTL_EXT_FLAG_A] & ~clr_ext_a);
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_reg <= tmr_pkg::CONTROL_RESET;
      ext_prev_a <= 1'b1;
      ext_prev_b <= 1'b1;
    end
    else
    begin
      control_reg <= next_control;
      ext_prev_a <= i_ext_irq_pin_a_n;
      ext_prev_b <= i_ext_irq_pin_b_n;
    end
  end

  // Requests need the source enable and the global enable
  logic glob;
  assign glob = irq_enable_reg[tmr_pkg::IEN_GLOBAL];

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_irq_timer_a <= 1'b0;
      o_irq_timer_b <= 1'b0;
      o_irq_ext_a <= 1'b0;
      o_irq_ext_b <= 1'b0;
    end
    else
    begin
      o_irq_timer_a <= control_reg[tmr_pkg::CTL_OVF_A] &
                       irq_enable_reg[tmr_pkg::IEN_TIMER_A] & glob;
      o_irq_timer_b <= control_reg[tmr_pkg::CTL_OVF_B] &
                       irq_enable_reg[tmr_pkg::IEN_TIMER_B] & glob;
      o_irq_ext_a <= control_reg[tmr_pkg::CTL_EXT_FLAG_A] &
                     irq_enable_reg[tmr_pkg::IEN_EXT_A] & glob;
      o_irq_ext_b <= control_reg[tmr_pkg::CTL_EXT_FLAG_B] &
                     irq_enable_reg[tmr_pkg::IEN_EXT_B] & glob;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/timer_pair_monitor.sv
/*
  Port checker for timer_pair_top: bus answer, read data, reset quiet,
  request clearing and the cause of the ext b request.
  Assumes one clock and one reset, bound from the bench top file.
*/
`timescale 1ns/1ns
`default_nettype none
module timer_pair_monitor (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_ext_irq_pin_b_n,
  input wire logic i_vector_timer_a,
  input wire logic i_vector_timer_b,
  input wire logic o_irq_timer_a,
  input wire logic o_irq_timer_b,
  input wire logic o_irq_ext_b
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  logic [7:0] idx;
  logic mapped;
  logic [2:0] low_age;
  logic [2:0] wr_age;
  assign idx = i_wb_adr[9:2];
  assign mapped = (idx >= tmr_pkg::IDX_CONTROL && idx <= tmr_pkg::IDX_HIGH_B) ||
    idx == tmr_pkg::IDX_IRQ_ENABLE;
  // Saturating ages: a rising ext request needs a recent pin low or write
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      low_age <= 3'h7;
      wr_age <= 3'h7;
    end
    else
    begin
      low_age <= !i_ext_irq_pin_b_n ? 3'h0 : low_age + 3'(low_age != 3'h7);
      wr_age <= (o_wb_ack && i_wb_we) ? 3'h0 : wr_age + 3'(wr_age != 3'h7);
    end
  end
  property p_ack_once;
    o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_ack_answer;
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acked");
  property p_rd_upper;
    o_wb_ack && !i_wb_we |-> o_wb_dat[31:8] == 24'h00_0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read lanes not zero");
  property p_unmapped;
    o_wb_ack && !i_wb_we && !mapped |-> o_wb_dat == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rst_quiet;
    disable iff (1'h0) !i_reset_n |-> !o_wb_ack && !o_irq_timer_a && !o_irq_timer_b;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
  property p_ext_b_cause;
    $rose(o_irq_ext_b) |-> low_age <= 3'h4 || wr_age <= 3'h4;
  endproperty
  a_ext_b_cause: assert property (p_ext_b_cause) else $error("ext b request uncaused");
  property p_vec_b;
    i_vector_timer_b |-> ##2 !o_irq_timer_b;
  endproperty
  a_vec_b: assert property (p_vec_b) else $error("vector b left request");
  property p_vec_a;
    i_vector_timer_a |-> ##2 !o_irq_timer_a;
  endproperty
  a_vec_a: assert property (p_vec_a) else $error("vector a left request");
  c_write: cover property (o_wb_ack && i_wb_we);
  c_irq_b: cover property ($rose(o_irq_timer_b));
  c_ext_b: cover property ($rose(o_irq_ext_b));
endmodule
`default_nettype wire

// >>> testbench/pin_model.sv
/*
  Far side count pin: a burst of falling edges on request.
  Assumes the bench raises i_go for one cycle while o_busy is low.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_model (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic [7:0] i_pulses,
  output logic o_pin,
  output logic o_busy
);
  int left = 0;
  int cnt = 0;
  initial o_pin = 1'h1;
  initial o_busy = 1'h0;
  // Each level held 12 clocks, two peripheral cycles, so every edge is sampled
  always @(posedge i_mclk)
  begin
    if (i_go && !o_busy)
    begin
      left <= 2 * i_pulses;
      cnt <= 0;
      o_busy <= 1'h1;
    end
    else if (o_busy && cnt != 11)
      cnt <= cnt + 1;
    else if (o_busy)
    begin
      cnt <= 0;
      o_busy <= left != 0;
      o_pin <= left != 0 ? ~o_pin : o_pin;
      left <= left != 0 ? left - 1 : 0;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
/*
  Self-checking bench for timer_pair_top with an integer count model.
  Assumes a 125 MHz clock; pins change only at rising edges.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic i_mclk = 1'h0, i_reset_n = 1'h1, go = 1'h0, busy;
  logic i_wb_cyc = 1'h0, i_wb_stb = 1'h0, i_wb_we = 1'h0;
  logic [9:0] i_wb_adr = 10'h000;
  logic [3:0] i_wb_sel = 4'h1;
  logic [31:0] i_wb_dat = 32'h0000_0000, o_wb_dat, rdv;
  logic o_wb_ack, o_irq_timer_a, o_irq_timer_b, o_irq_ext_a, o_irq_ext_b, pin_b;
  logic i_ext_irq_pin_a_n = 1'h1, i_ext_irq_pin_b_n = 1'h1;
  logic [3:0] vec = 4'h0;
  logic [7:0] pulses = 8'h00;
  int err_count = 0, cmp_count = 0, cyc_n = 0, lo, hi, ovf, n, k;
  always #4 i_mclk = ~i_mclk;
  timer_pair_top i_dut (.i_mclk, .i_reset_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_count_input_pin_a(1'h1),
    .i_count_input_pin_b(pin_b), .i_ext_irq_pin_a_n, .i_ext_irq_pin_b_n,
    .i_vector_timer_a(vec[0]), .i_vector_timer_b(vec[1]), .i_vector_ext_a(vec[2]),
    .i_vector_ext_b(vec[3]), .o_irq_timer_a, .o_irq_timer_b, .o_irq_ext_a, .o_irq_ext_b);
  pin_model i_pins (.i_mclk, .i_go(go), .i_pulses(pulses), .o_pin(pin_b), .o_busy(busy));
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge i_mclk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 40000)
    begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge i_mclk);
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we <= w;
    i_wb_adr <= {idx, 2'h0};
    i_wb_dat <= {24'h00_0000, d};
    @(posedge i_mclk);
    while (o_wb_ack !== 1'h1) @(posedge i_mclk);
    rdv = o_wb_dat;
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'h0, idx, 8'h00);
    chk(rdv, {24'h00_0000, exp});
  endtask
  // Requests are registered: look at them on a falling edge after settling
  task automatic lag;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
  task automatic pulse(input int v);
    @(posedge i_mclk);
    vec[v] <= 1'h1;
    @(posedge i_mclk);
    vec <= 4'h0;
    lag();
  endtask
  initial
  begin
    i_reset_n <= 1'h0;
    void'($urandom(63));
    repeat (8) @(posedge i_mclk);
    i_reset_n <= 1'h1;
    repeat (3) @(posedge i_mclk);
    rdc(tmr_pkg::IDX_CONTROL, 8'h00);
    rdc(tmr_pkg::IDX_MODE, 8'h00);
    rdc(tmr_pkg::IDX_IRQ_ENABLE, 8'h00);
    bus(1'h1, 8'h90, 8'hff);
    rdc(8'h90, 8'h00);
    i_ext_irq_pin_b_n <= 1'h0;
    for (int m = 0; m < 4; m++)
      for (int r = 0; r < 3; r++)
      begin
        lo = 224 + $urandom % 32;
        hi = m == 2 ? $urandom % 256 : 254 + $urandom % 2;
        n = 1 + $urandom % 40;
        bus(1'h1, tmr_pkg::IDX_CONTROL, 8'h00);
        bus(1'h1, tmr_pkg::IDX_MODE, 8'(8'h80 | (m << 4)));
        bus(1'h1, tmr_pkg::IDX_LOW_B, 8'(lo));
        bus(1'h1, tmr_pkg::IDX_HIGH_B, 8'(hi));
        bus(1'h1, tmr_pkg::IDX_CONTROL, 8'h40);
        // Gate window of 6n clocks holds exactly n peripheral ticks
        @(posedge i_mclk);
        i_ext_irq_pin_b_n <= 1'h1;
        repeat (6 * n) @(posedge i_mclk);
        i_ext_irq_pin_b_n <= 1'h0;
        repeat (4) @(posedge i_mclk);
        ovf = 0;
        repeat (n)
        begin
          if (m == 2 && lo == 255) ovf = 1;
          case (m)
            0: lo = (lo & 224) | ((lo + 1) & 31);
            1: lo = (lo + 1) % 256;
            2: lo = lo == 255 ? hi : lo + 1;
            default: ;
          endcase
          if (m < 2 && (lo & (m == 0 ? 31 : 255)) == 0) hi = hi + 1;
          if (hi == 256) {hi, ovf} = {32'h0000_0000, 32'h0000_0001};
        end
        rdc(tmr_pkg::IDX_CONTROL, 8'(8'h48 | (ovf << 7)));
        rdc(tmr_pkg::IDX_LOW_B, 8'(lo));
        rdc(tmr_pkg::IDX_HIGH_B, 8'(hi));
      end
    lo = $urandom % 200;
    k = 1 + $urandom % 8;
    bus(1'h1, tmr_pkg::IDX_MODE, 8'h50);
    bus(1'h1, tmr_pkg::IDX_LOW_B, 8'(lo));
    bus(1'h1, tmr_pkg::IDX_CONTROL, 8'h40);
    @(posedge i_mclk);
    pulses <= 8'(k);
    go <= 1'h1;
    @(posedge i_mclk);
    go <= 1'h0;
    @(posedge i_mclk);
    while (busy !== 1'h0) @(posedge i_mclk);
    bus(1'h1, tmr_pkg::IDX_CONTROL, 8'h00);
    rdc(tmr_pkg::IDX_LOW_B, 8'(lo + k));
    bus(1'h1, tmr_pkg::IDX_MODE, 8'h03);
    bus(1'h1, tmr_pkg::IDX_LOW_B, 8'h1f);
    bus(1'h1, tmr_pkg::IDX_HIGH_B, 8'hff);
    bus(1'h1, tmr_pkg::IDX_HIGH_A, 8'hfe);
    repeat (30) @(posedge i_mclk);
    rdc(tmr_pkg::IDX_CONTROL, 8'h08);
    bus(1'h1, tmr_pkg::IDX_CONTROL, 8'h40);
    repeat (30) @(posedge i_mclk);
    rdc(tmr_pkg::IDX_CONTROL, 8'hc8);
    bus(1'h1, tmr_pkg::IDX_MODE, 8'h30);
    bus(1'h1, tmr_pkg::IDX_CONTROL, 8'h80);
    foreach (pulses[i])
    begin
      k = {i[0], 3'h0, i[1], 3'h0};
      bus(1'h1, tmr_pkg::IDX_IRQ_ENABLE, 8'(k | 8'h08 * int'(i > 3)));
      lag();
      chk(o_irq_timer_b, 32'(i == 3 || i == 5 || i == 7));
    end
    bus(1'h1, tmr_pkg::IDX_IRQ_ENABLE, 8'h88);
    pulse(1);
    chk(o_irq_timer_b, 32'h0000_0000);
    bus(1'h1, tmr_pkg::IDX_IRQ_ENABLE, 8'h87);
    bus(1'h1, tmr_pkg::IDX_CONTROL, 8'h20);
    lag();
    chk({o_irq_timer_a, o_irq_ext_b}, 32'h0000_0003);
    pulse(0);
    pulse(3);
    chk({o_irq_timer_a, o_irq_ext_b}, 32'h0000_0001);
    bus(1'h1, tmr_pkg::IDX_CONTROL, 8'h05);
    // Level set wins the first clear; clear again once edge type
    bus(1'h1, tmr_pkg::IDX_CONTROL, 8'h05);
    lag();
    chk(o_irq_ext_b, 32'h0000_0000);
    @(posedge i_mclk);
    i_ext_irq_pin_b_n <= 1'h1;
    i_ext_irq_pin_a_n <= 1'h0;
    @(posedge i_mclk);
    i_ext_irq_pin_b_n <= 1'h0;
    lag();
    chk({o_irq_ext_a, o_irq_ext_b}, 32'h0000_0003);
    pulse(2);
    pulse(3);
    chk({o_irq_ext_a, o_irq_ext_b}, 32'h0000_0000);
    bus(1'h1, tmr_pkg::IDX_CONTROL, 8'h00);
    pulse(2);
    chk(o_irq_ext_a, 32'h0000_0001);
    test_done();
  end
endmodule
bind timer_pair_top timer_pair_monitor i_mon (.i_mclk, .i_reset_n, .i_wb_cyc, .i_wb_stb,
  .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack, .i_ext_irq_pin_b_n, .i_vector_timer_a,
  .i_vector_timer_b, .o_irq_timer_a, .o_irq_timer_b, .o_irq_ext_b);
`default_nettype wire
